/* hw/lprb_regs.vh */
// register offsets, field positions and reset values of the light/proximity register bank
// included by the register bank module; definitions only
`ifndef LPRB_REGS_VH
`define LPRB_REGS_VH

`define LPRB_ADDR_W 8
`define LPRB_OFF_ANALOG_CONTROL 8'h0f
`define LPRB_OFF_SILICON_REVISION 8'h11
`define LPRB_OFF_PART_IDENTITY 8'h12
`define LPRB_OFF_DEVICE_STATUS 8'h13
`define LPRB_OFF_LIGHT_CH0_LOW 8'h14
`define LPRB_OFF_LIGHT_CH0_HIGH 8'h15
`define LPRB_OFF_LIGHT_CH1_LOW 8'h16
`define LPRB_OFF_LIGHT_CH1_HIGH 8'h17
`define LPRB_OFF_PROX_RESULT_LOW 8'h18
`define LPRB_OFF_PROX_RESULT_HIGH 8'h19
`define LPRB_OFF_PROX_OFFSET_COMP 8'h1e

`define LPRB_ANALOG_CONTROL_RST 8'h00
`define LPRB_STATUS_RST 8'h00
`define LPRB_RESULT_RST 16'h0000
`define LPRB_UNMAPPED_READ 8'h00

// analog control fields
`define LPRB_DRIVE_MSB 7
`define LPRB_DRIVE_LSB 6
`define LPRB_DIODE_MSB 5
`define LPRB_DIODE_LSB 4
`define LPRB_PROX_GAIN_SELECT_MSB 3
`define LPRB_PROX_GAIN_SELECT_LSB 2
`define LPRB_LIGHT_GAIN_SELECT_MSB 1
`define LPRB_LIGHT_GAIN_SELECT_LSB 0
`define LPRB_DIODE_RESERVED 2'b11
`define LPRB_DIODE_CH0 2'b01
`define LPRB_DIODE_CH1 2'b10
`define LPRB_FIELD_RST 2'b00
`define LPRB_SHADOW_RST 8'h00

// gain decodes
`define LPRB_PROX_GAIN_SELECT_X1 4'h1
`define LPRB_PROX_GAIN_SELECT_X2 4'h2
`define LPRB_PROX_GAIN_SELECT_X4 4'h4
`define LPRB_PROX_GAIN_SELECT_X8 4'h8
`define LPRB_LIGHT_GAIN_SELECT_X1 7'h01
`define LPRB_LIGHT_GAIN_SELECT_X8 7'h08
`define LPRB_LIGHT_GAIN_SELECT_X16 7'h10
`define LPRB_LIGHT_GAIN_SELECT_X120 7'h78

// status fields
`define LPRB_ST_PROX_SATURATED_FLAG 6
`define LPRB_ST_PROX_IRQ_FLAG 5
`define LPRB_ST_LIGHT_IRQ_FLAG 4
`define LPRB_ST_PROX_RESULT_READY 1
`define LPRB_ST_LIGHT_RESULT_READY 0

// revision fields
`define LPRB_REV_MSB 3
`define LPRB_REV_LSB 0
`define LPRB_REV_RSVD 4'h0

// offset fields
`define LPRB_OFS_SIGN 7
`define LPRB_OFS_MAG_MSB 6
`define LPRB_OFS_MAG_LSB 0

// drive strength in tenths of a percent, full and reduced (divided by nine)
`define LPRB_DRV_FULL 10'd1000
`define LPRB_DRV_DIVISOR 10'd9

`endif

/* hw/lprb_light_proximity_register_bank.v */
// register bank of the light and proximity sensor, upper part of the map
// assumes an external serial front end giving byte reads/writes with auto-increment,
// and a measurement engine giving results and status events on plain ports
`timescale 1ns/1ps
`include "lprb_regs.vh"
`default_nettype none

module lprb_light_proximity_register_bank #(
    parameter [3:0] DIE_REVISION = 4'h1,     // arbitrary value
    parameter [7:0] PART_ID = 8'h5a,         // arbitrary value
    parameter [7:0] OFFSET_TRIM = 8'h00      // factory trim, plain default
) (
    input wire core_clk,
    input wire reset_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`LPRB_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reduced_drive_bit,
    input wire prox_enable_bit,
    input wire light_enable_bit,
    input wire light_ch0_done,
    input wire [15:0] light_ch0_value,
    input wire light_ch1_done,
    input wire [15:0] light_ch1_value,
    input wire prox_done,
    input wire [15:0] prox_value,
    input wire prox_saturated_in,
    input wire prox_irq_active,
    input wire light_irq_active,
    output reg [7:0] reg_rdata,
    output reg [1:0] led_drive_strength,
    output reg [1:0] prox_diode_select,
    output reg [1:0] prox_gain_select,
    output reg [1:0] light_gain_select,
    output reg [9:0] led_drive_permille,
    output reg [3:0] prox_gain_factor,
    output reg [6:0] light_gain_factor,
    output reg diode_ch0_connect,
    output reg diode_ch1_connect,
    output reg offset_sign_positive,
    output reg [6:0] offset_magnitude
);

    reg [7:0] analog_control;
    reg [7:0] prox_offset_comp;
    reg prox_saturated_flag;
    reg prox_result_ready;
    reg light_result_ready;
    reg [15:0] light_ch0_data;
    reg [15:0] light_ch1_data;
    reg [15:0] prox_data;
    reg [7:0] light_ch0_shadow;
    reg [7:0] light_ch1_shadow;
    reg [7:0] prox_shadow;
    reg [7:0] next_rdata;
    reg [7:0] next_control;
    wire [7:0] device_status;
    // control field codes and decoded accesses
    wire [1:0] drive_code;
    wire [1:0] diode_code;
    wire [1:0] prox_gain_select_code;
    wire [1:0] light_gain_select_code;
    wire wr_control;
    wire wr_offset;
    wire rd_ch0_low;
    wire rd_ch1_low;
    wire rd_prox_low;

    // drive percentage in tenths: halves per code step, divided by nine when reduced
    function [9:0] drive_permille;
        input [1:0] code;
        input reduced;
        reg [9:0] base;
        begin
            base = `LPRB_DRV_FULL >> code;
            drive_permille = reduced ? (base / `LPRB_DRV_DIVISOR) : base;
        end
    endfunction

    function [6:0] light_gain_of;
        input [1:0] code;
        begin
            case (code)
                2'b00: light_gain_of = `LPRB_LIGHT_GAIN_SELECT_X1;
                2'b01: light_gain_of = `LPRB_LIGHT_GAIN_SELECT_X8;
                2'b10: light_gain_of = `LPRB_LIGHT_GAIN_SELECT_X16;
                default: light_gain_of = `LPRB_LIGHT_GAIN_SELECT_X120;
            endcase
        end
    endfunction

    // proximity gain doubles per code step
    function [3:0] prox_gain_of;
        input [1:0] code;
        begin
            case (code)
                2'b00: prox_gain_of = `LPRB_PROX_GAIN_SELECT_X1;
                2'b01: prox_gain_of = `LPRB_PROX_GAIN_SELECT_X2;
                2'b10: prox_gain_of = `LPRB_PROX_GAIN_SELECT_X4;
                default: prox_gain_of = `LPRB_PROX_GAIN_SELECT_X8;
            endcase
        end
    endfunction

    // one decoded access: strobe high and address matching
    function hit;
        input strobe;
        input [`LPRB_ADDR_W-1:0] addr;
        input [`LPRB_ADDR_W-1:0] target;
        begin
            hit = strobe && (addr == target);
        end
    endfunction

    assign device_status = {1'b0, prox_saturated_flag, prox_irq_active, light_irq_active,
                            2'b00, prox_result_ready, light_result_ready};

    // field slices and access strobes
    assign drive_code = analog_control[`LPRB_DRIVE_MSB:`LPRB_DRIVE_LSB];
    assign diode_code = analog_control[`LPRB_DIODE_MSB:`LPRB_DIODE_LSB];
    assign prox_gain_select_code = analog_control[`LPRB_PROX_GAIN_SELECT_MSB:`LPRB_PROX_GAIN_SELECT_LSB];
    assign light_gain_select_code = analog_control[`LPRB_LIGHT_GAIN_SELECT_MSB:`LPRB_LIGHT_GAIN_SELECT_LSB];
    assign wr_control = hit(reg_wr, reg_addr, `LPRB_OFF_ANALOG_CONTROL);
    assign wr_offset = hit(reg_wr, reg_addr, `LPRB_OFF_PROX_OFFSET_COMP);
    assign rd_ch0_low = hit(reg_rd, reg_addr, `LPRB_OFF_LIGHT_CH0_LOW);
    assign rd_ch1_low = hit(reg_rd, reg_addr, `LPRB_OFF_LIGHT_CH1_LOW);
    assign rd_prox_low = hit(reg_rd, reg_addr, `LPRB_OFF_PROX_RESULT_LOW);

    // a reserved diode code keeps the previous selection
    always @* begin
        next_control = reg_wdata;
        if (reg_wdata[`LPRB_DIODE_MSB:`LPRB_DIODE_LSB] == `LPRB_DIODE_RESERVED) begin
            next_control[`LPRB_DIODE_MSB:`LPRB_DIODE_LSB] =
                analog_control[`LPRB_DIODE_MSB:`LPRB_DIODE_LSB];
        end
    end

    // read data multiplexer; high bytes return the shadows
    always @* begin
        case (reg_addr)
            `LPRB_OFF_ANALOG_CONTROL: next_rdata = analog_control;
            `LPRB_OFF_SILICON_REVISION: next_rdata = {`LPRB_REV_RSVD, DIE_REVISION};
            `LPRB_OFF_PART_IDENTITY: next_rdata = PART_ID;
            `LPRB_OFF_DEVICE_STATUS: next_rdata = device_status;
            `LPRB_OFF_LIGHT_CH0_LOW: next_rdata = light_ch0_data[7:0];
            `LPRB_OFF_LIGHT_CH0_HIGH: next_rdata = light_ch0_shadow;
            `LPRB_OFF_LIGHT_CH1_LOW: next_rdata = light_ch1_data[7:0];
            `LPRB_OFF_LIGHT_CH1_HIGH: next_rdata = light_ch1_shadow;
            `LPRB_OFF_PROX_RESULT_LOW: next_rdata = prox_data[7:0];
            `LPRB_OFF_PROX_RESULT_HIGH: next_rdata = prox_shadow;
            `LPRB_OFF_PROX_OFFSET_COMP: next_rdata = prox_offset_comp;
            default: next_rdata = `LPRB_UNMAPPED_READ;
        endcase
    end

    // register writes; read data stands until the next read
    always @(posedge core_clk) begin
        if (!reset_n) begin
            analog_control <= `LPRB_ANALOG_CONTROL_RST;
            prox_offset_comp <= OFFSET_TRIM;
            reg_rdata <= `LPRB_UNMAPPED_READ;
        end else begin
            if (wr_control) begin
                analog_control <= next_control;
            end
            if (wr_offset) begin
                prox_offset_comp <= reg_wdata;
            end
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // status flags: set by engine events, enable drop clears valid and wins over a done pulse
    always @(posedge core_clk) begin
        if (!reset_n) begin
            prox_saturated_flag <= 1'b0;
            prox_result_ready <= 1'b0;
            light_result_ready <= 1'b0;
        end else begin
            if (prox_done) begin
                prox_saturated_flag <= prox_saturated_in;
            end
            if (prox_done && prox_enable_bit) begin
                prox_result_ready <= 1'b1;
            end else if (!prox_enable_bit) begin
                prox_result_ready <= 1'b0;
            end
            if (light_ch0_done && light_enable_bit) begin
                light_result_ready <= 1'b1;
            end else if (!light_enable_bit) begin
                light_result_ready <= 1'b0;
            end
        end
    end

    // result registers load with their done pulse
    always @(posedge core_clk) begin
        if (!reset_n) begin
            light_ch0_data <= `LPRB_RESULT_RST;
            light_ch1_data <= `LPRB_RESULT_RST;
            prox_data <= `LPRB_RESULT_RST;
        end else begin
            if (light_ch0_done) begin
                light_ch0_data <= light_ch0_value;
            end
            if (light_ch1_done) begin
                light_ch1_data <= light_ch1_value;
            end
            if (prox_done) begin
                prox_data <= prox_value;
            end
        end
    end

    // one shadow per result: the high byte freezes at the low-byte read,
    // so a conversion ending between the two reads cannot tear the value
    always @(posedge core_clk) begin
        if (!reset_n) begin
            light_ch0_shadow <= `LPRB_SHADOW_RST;
            light_ch1_shadow <= `LPRB_SHADOW_RST;
            prox_shadow <= `LPRB_SHADOW_RST;
        end else begin
            if (rd_ch0_low) begin
                light_ch0_shadow <= light_ch0_data[15:8];
            end
            if (rd_ch1_low) begin
                light_ch1_shadow <= light_ch1_data[15:8];
            end
            if (rd_prox_low) begin
                prox_shadow <= prox_data[15:8];
            end
        end
    end

    // registered copies of the control fields
    always @(posedge core_clk) begin
        if (!reset_n) begin
            led_drive_strength <= `LPRB_FIELD_RST;
            prox_diode_select <= `LPRB_FIELD_RST;
            prox_gain_select <= `LPRB_FIELD_RST;
            light_gain_select <= `LPRB_FIELD_RST;
        end else begin
            led_drive_strength <= drive_code;
            prox_diode_select <= diode_code;
            prox_gain_select <= prox_gain_select_code;
            light_gain_select <= light_gain_select_code;
        end
    end

    // decoded drive, gains and diode connections; a reserved diode code never gets here
    always @(posedge core_clk) begin
        if (!reset_n) begin
            led_drive_permille <= `LPRB_DRV_FULL;
            prox_gain_factor <= `LPRB_PROX_GAIN_SELECT_X1;
            light_gain_factor <= `LPRB_LIGHT_GAIN_SELECT_X1;
            diode_ch0_connect <= 1'b0;
            diode_ch1_connect <= 1'b0;
        end else begin
            led_drive_permille <= drive_permille(drive_code, reduced_drive_bit);
            prox_gain_factor <= prox_gain_of(prox_gain_select_code);
            light_gain_factor <= light_gain_of(light_gain_select_code);
            diode_ch0_connect <= (diode_code == `LPRB_DIODE_CH0);
            diode_ch1_connect <= (diode_code == `LPRB_DIODE_CH1);
        end
    end

    // offset fields; reset shows the factory trim at once, as the register does
    always @(posedge core_clk) begin
        if (!reset_n) begin
            offset_sign_positive <= OFFSET_TRIM[`LPRB_OFS_SIGN];
            offset_magnitude <= OFFSET_TRIM[`LPRB_OFS_MAG_MSB:`LPRB_OFS_MAG_LSB];
        end else begin
            offset_sign_positive <= prox_offset_comp[`LPRB_OFS_SIGN];
            offset_magnitude <= prox_offset_comp[`LPRB_OFS_MAG_MSB:`LPRB_OFS_MAG_LSB];
        end
    end

endmodule // lprb_light_proximity_register_bank

`default_nettype wire

/* verif/lprb_properties.sv */
// port-level checker of the light/proximity register bank
// sees the bank's ports only; bound to every bank instance below
`timescale 1ns/1ps
`default_nettype none
module lprb_properties #(
    parameter [3:0] DIE_REVISION = 4'h1,
    parameter [7:0] PART_ID = 8'h5a,
    parameter [7:0] OFFSET_TRIM = 8'h00
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reduced_drive_bit,
    input wire logic prox_irq_active,
    input wire logic light_irq_active,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] led_drive_strength,
    input wire logic [1:0] prox_diode_select,
    input wire logic [1:0] prox_gain_select,
    input wire logic [1:0] light_gain_select,
    input wire logic [9:0] led_drive_permille,
    input wire logic [3:0] prox_gain_factor,
    input wire logic offset_sign_positive,
    input wire logic [6:0] offset_magnitude
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    chk_ident_read: assert property (reg_rd && reg_addr == 8'h12 |=> reg_rdata == PART_ID)
        else $error("identity read wrong");
    chk_rev_read: assert property (reg_rd && reg_addr == 8'h11 |=> reg_rdata[3:0] == DIE_REVISION)
        else $error("revision read wrong");
    chk_status_zero: assert property (reg_rd && reg_addr == 8'h13 |=> !reg_rdata[7] && reg_rdata[3:2] == 2'b00)
        else $error("status reserved bits set");
    chk_irq_mirror: assert property (reg_rd && reg_addr == 8'h13 |=>
        reg_rdata[5:4] == {$past(prox_irq_active), $past(light_irq_active)}) else $error("irq flags wrong");
    chk_drive_scale: assert property (led_drive_permille ==
        (10'd1000 >> led_drive_strength) / ($past(reduced_drive_bit) ? 10'd9 : 10'd1)) else $error("drive wrong");
    chk_prox_gain_select_decode: assert property (prox_gain_factor == 4'd1 << prox_gain_select)
        else $error("prox gain wrong");
    chk_ctrl_write: assert property (reg_wr && reg_addr == 8'h0f && reg_wdata[5:4] != 2'b11 |-> ##2
        {led_drive_strength, prox_diode_select, prox_gain_select, light_gain_select} == $past(reg_wdata, 2))
        else $error("control fields wrong");
    chk_diode_keep: assert property (reg_wr && reg_addr == 8'h0f && reg_wdata[5:4] == 2'b11 |-> ##2
        prox_diode_select == $past(prox_diode_select)) else $error("reserved diode code taken");
    chk_trim_reload: assert property ($rose(reset_n) |-> {offset_sign_positive, offset_magnitude} == OFFSET_TRIM)
        else $error("offset not trimmed");
endmodule // lprb_properties
bind lprb_light_proximity_register_bank lprb_properties #(.DIE_REVISION(DIE_REVISION), .PART_ID(PART_ID),
    .OFFSET_TRIM(OFFSET_TRIM)) i_props (.core_clk(core_clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reduced_drive_bit(reduced_drive_bit),
    .prox_irq_active(prox_irq_active), .light_irq_active(light_irq_active), .reg_rdata(reg_rdata),
    .led_drive_strength(led_drive_strength), .prox_diode_select(prox_diode_select),
    .prox_gain_select(prox_gain_select), .light_gain_select(light_gain_select),
    .led_drive_permille(led_drive_permille), .prox_gain_factor(prox_gain_factor),
    .offset_sign_positive(offset_sign_positive), .offset_magnitude(offset_magnitude));
`default_nettype wire

/* verif/lprb_host_model.sv */
// host model: byte accesses as the serial front end hands them on
// assumes the bench owns the clock and drains exp_q one entry per read
`timescale 1ns/1ps
`default_nettype none
module lprb_host_model (
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    logic [15:0] exp_q[$];
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one request per edge, changed 1 ns after it; reads note mask and value
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
        input logic [7:0] m, input logic [7:0] e);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        if (r)
            exp_q.push_back({m, e});
        @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, (a == 8'h0f && d[5:4] == 2'b11) ? {d[7:6], 2'b00, d[3:0]} : d, 8'h00, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, 1'b1, a, ~reg_wdata, 8'hff, e);
    endtask
    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 8'h01, e[15:8]);
    endtask
    task automatic idle;
        acc(1'b0, 1'b0, ~reg_addr, ~reg_wdata, 8'h00, 8'h00);
    endtask
endmodule // lprb_host_model
`default_nettype wire

/* verif/tb.sv */
// bench of the light/proximity register bank with engine strobes and read queue
// assumes host model and checker compiled ahead
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [3:0] REV = 4'h3; // arbitrary value
    localparam logic [7:0] IDV = 8'ha7; // arbitrary value
    localparam logic [7:0] TRIM = 8'hc5;
    localparam logic [6:0] LG[4] = '{7'h01, 7'h08, 7'h10, 7'h78};
    logic core_clk = 1'b0, reset_n = 1'b0, reduced_drive_bit = 1'b0, prox_enable_bit = 1'b1, rd_pend = 1'b0;
    logic light_enable_bit = 1'b1, prox_saturated_in = 1'b0, prox_irq_active = 1'b0, light_irq_active = 1'b0;
    logic [2:0] dn = 3'b000;
    logic [15:0] vals[3] = '{default: 16'h0000};
    logic [15:0] wv[3];
    logic [15:0] v, ex;
    logic [7:0] ctl, la;
    wire logic reg_wr, reg_rd, offset_sign_positive;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
    wire logic [6:0] offset_magnitude;
    wire logic [6:0] light_gain_factor;
    wire logic diode_ch0_connect, diode_ch1_connect;
    int failures = 0, compares = 0, seed;
    logic [7:0] ra[11] = '{8'h0f, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1e};
    lprb_host_model i_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    lprb_light_proximity_register_bank #(.DIE_REVISION(REV), .PART_ID(IDV), .OFFSET_TRIM(TRIM)) i_dut (
        .core_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reduced_drive_bit, .prox_enable_bit,
        .light_enable_bit, .light_ch0_done(dn[0]), .light_ch0_value(vals[0]), .light_ch1_done(dn[1]),
        .light_ch1_value(vals[1]), .prox_done(dn[2]), .prox_value(vals[2]), .prox_saturated_in,
        .prox_irq_active, .light_irq_active, .reg_rdata, .led_drive_strength(), .prox_diode_select(),
        .prox_gain_select(), .light_gain_select(), .led_drive_permille(), .prox_gain_factor(),
        .light_gain_factor, .diode_ch0_connect, .diode_ch1_connect, .offset_sign_positive,
        .offset_magnitude);
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) dn <= 3'b000;
    always @(posedge core_clk) rd_pend <= reg_rd & reset_n;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic eng(input int c, input logic [15:0] x);
        dn = 3'b001 << c;
        vals[c] = x;
        prox_saturated_in = x[0];
    endtask
    always @(negedge core_clk) begin
        if (rd_pend) begin
            ex = i_host.exp_q.pop_front();
            check({8'h00, reg_rdata & ex[15:8]}, {8'h00, ex[7:0]});
        end
    end
    initial begin
        #20000;
        failures++;
        stop_test;
    end
    initial begin
        seed = $urandom(32'h8cc7);
        repeat (16) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        foreach (ra[i]) if (ra[i] != 8'h0f && ra[i] != 8'h1e) i_host.wr(ra[i], 8'($urandom));
        foreach (ra[i]) i_host.rd(ra[i], ra[i] == 8'h12 ? IDV : ra[i] == 8'h1e ? TRIM : 8'h00);
        i_host.acc(1'b0, 1'b1, 8'h11, 8'h00, 8'h0f, {4'h0, REV});
        for (int i = 0; i < 4; i++) begin
            reduced_drive_bit = i[0];
            ctl = {i[1:0], 2'(i % 3), 2'(3 - i), i[1:0]};
            i_host.wr(8'h0f, ctl);
            i_host.rd(8'h0f, ctl);
            check({9'h000, light_gain_factor}, {9'h000, LG[i]});
            check({14'h0000, diode_ch1_connect, diode_ch0_connect}, {14'h0000, ctl[5], ctl[4]});
        end
        reduced_drive_bit = 1'b0;
        i_host.acc(1'b1, 1'b0, 8'h0f, 8'hf0, 8'h00, 8'h00);
        i_host.rd(8'h0f, 8'hc0);
        check({14'h0000, diode_ch1_connect, diode_ch0_connect}, 16'h0000);
        v = 16'($urandom);
        i_host.wr(8'h1e, v[7:0]);
        i_host.rd(8'h1e, v[7:0]);
        check({9'h000, offset_magnitude}, {9'h000, v[6:0]});
        check({15'h0000, offset_sign_positive}, {15'h0000, v[7]});
        for (int c = 0; c < 3; c++) begin
            v = 16'($urandom);
            wv[c] = 16'($urandom);
            la = 8'(8'h14 + 2 * c);
            eng(c, v);
            i_host.idle;
            i_host.rd(la, v[7:0]);
            eng(c, wv[c]);
            i_host.rd(la + 8'h01, v[15:8]);
            i_host.rd16(la, wv[c]);
        end
        i_host.rd(8'h14, wv[0][7:0]);
        i_host.rd(8'h16, wv[1][7:0]);
        i_host.rd(8'h15, wv[0][15:8]);
        {prox_irq_active, light_irq_active} = 2'($urandom);
        i_host.rd(8'h13, {1'b0, wv[2][0], prox_irq_active, light_irq_active, 4'b0011});
        prox_enable_bit = 1'b0;
        light_enable_bit = 1'b0;
        i_host.idle;
        eng(2, ~wv[2]);
        i_host.idle;
        {prox_irq_active, light_irq_active} = ~{prox_irq_active, light_irq_active};
        i_host.rd(8'h13, {1'b0, ~wv[2][0], prox_irq_active, light_irq_active, 4'b0000});
        reset_n = 1'b0;
        repeat (3) i_host.idle;
        reset_n = 1'b1;
        i_host.rd(8'h1e, TRIM);
        i_host.idle;
        stop_test;
    end
endmodule // tb
`default_nettype wire
